// ### design/pxw_line_fifo_mem.sv
`timescale 1ns/10ps
`include "pxw_map.svh"
module pxw_line_fifo_mem
(
   // Write side, link clock
   input wire logic wclk,
   pxw_fifo_if.mw w,
   // Read side, core clock
   input wire logic rclk,
   pxw_fifo_if.mr r
);
   import pxw_pkg::*;
   logic [`PXW_ENT_W-1:0] mem_q [0:(1<<`PXW_AW)-1];
   logic [`PXW_ENT_W-1:0] rdata_q;

   always_ff @(posedge wclk)
   begin
      if (w.we)
      begin
         mem_q[w.waddr] <= w.wdata;
      end
   end

   always_ff @(posedge rclk)
   begin
      if (r.re)
      begin
         rdata_q <= mem_q[r.raddr];
      end
   end

   assign r.rdata = rdata_q;
endmodule // pxw_line_fifo_mem

// ### design/pxw_link_rx.sv
`timescale 1ns/10ps
`include "pxw_map.svh"
module pxw_link_rx
(
   // Link clock and pins
   input wire logic link_clk,
   input wire logic [`PXW_DATA_W-1:0] link_data,
   input wire logic link_fval,
   input wire logic link_lval,
   // Core domain levels
   input wire logic srst,
   input wire logic run,
   output logic overflow,
   // FIFO write side
   pxw_fifo_if.wr f
);
   import pxw_pkg::*;
   logic rst_s1_q, rst_s2_q, run_s1_q, run_s2_q;
   logic [`PXW_PW-1:0] rg_s1_q, rg_s2_q;
   logic [`PXW_DATA_W-1:0] cap_d_q, cap_d_d, hold_q, hold_d;
   logic cap_l_q, cap_l_d, cap_f_q, cap_f_d, lprev_q, lprev_d;
   logic hold_v_q, hold_v_d, hsof_q, hsof_d, hsol_q, hsol_d;
   logic sofp_q, sofp_d, ovf_q, ovf_d, full, push, push_eol;
   logic [`PXW_PW-1:0] wptr_q, wptr_d, wgray_q, wgray_d;

   // ------
   // Crossings into the link domain
   // ------
   always_ff @(posedge link_clk)
   begin
      rst_s1_q <= srst;
      rst_s2_q <= rst_s1_q;
      run_s1_q <= run;
      run_s2_q <= run_s1_q;
      rg_s1_q <= f.rgray;
      rg_s2_q <= rg_s1_q;
   end

   // ------
   // Word capture and FIFO write
   // ------
   always_comb
   begin
      cap_d_d = link_data;
      cap_l_d = link_lval;
      cap_f_d = link_fval;
      lprev_d = cap_l_q;
      hold_d = hold_q;
      hold_v_d = hold_v_q;
      hsof_d = hsof_q;
      hsol_d = hsol_q;
      sofp_d = sofp_q;
      ovf_d = ovf_q;
      wptr_d = wptr_q;
      push = 1'b0;
      push_eol = 1'b0;
      full = wgray_q == {~rg_s2_q[4:3], rg_s2_q[2:0]};
      if (run_s2_q && cap_l_q && cap_f_q)
      begin
         // Every link word is taken whole, one per cycle
         push = hold_v_q;
         hold_d = cap_d_q;
         hold_v_d = 1'b1;
         hsof_d = sofp_q;
         hsol_d = !lprev_q;
         sofp_d = 1'b0;
      end
      else if (hold_v_q)
      begin
         // Last word of a line carries the line end mark
         push = 1'b1;
         push_eol = 1'b1;
         hold_v_d = 1'b0;
      end
      if (!cap_f_q)
      begin
         sofp_d = 1'b1;
      end
      if (push && full)
      begin
         ovf_d = 1'b1;
      end
      else if (push)
      begin
         wptr_d = wptr_q + 5'h01;
      end
      wgray_d = wptr_d ^ (wptr_d >> 1);
   end

   always_ff @(posedge link_clk)
   begin
      if (rst_s2_q)
      begin
         cap_d_q <= '0;
         cap_l_q <= 1'b0;
         cap_f_q <= 1'b0;
         lprev_q <= 1'b0;
         hold_q <= '0;
         hold_v_q <= 1'b0;
         hsof_q <= 1'b0;
         hsol_q <= 1'b0;
         sofp_q <= 1'b1;
         ovf_q <= 1'b0;
         wptr_q <= '0;
         wgray_q <= '0;
      end
      else
      begin
         cap_d_q <= cap_d_d;
         cap_l_q <= cap_l_d;
         cap_f_q <= cap_f_d;
         lprev_q <= lprev_d;
         hold_q <= hold_d;
         hold_v_q <= hold_v_d;
         hsof_q <= hsof_d;
         hsol_q <= hsol_d;
         sofp_q <= sofp_d;
         ovf_q <= ovf_d;
         wptr_q <= wptr_d;
         wgray_q <= wgray_d;
      end
   end

   // Component i sits at bits 10i+9..10i, untouched
   assign f.wdata = {push_eol, hsol_q, hsof_q, hold_q};
   assign f.we = push && !full;
   assign f.waddr = wptr_q[`PXW_AW-1:0];
   assign f.wgray = wgray_q;
   assign overflow = ovf_q;

   a_word_kept: assert property (
      @(posedge link_clk) disable iff (rst_s2_q)
      (run_s2_q && cap_l_q && cap_f_q && hold_v_q && !full)
      |-> f.we && f.wdata[`PXW_DATA_W-1:0] == hold_q
         ##1 hold_q == $past(cap_d_q))
      else $error("link word not passed whole");

   a_eol_flush: assert property (
      @(posedge link_clk) disable iff (rst_s2_q)
      (hold_v_q && !(run_s2_q && cap_l_q && cap_f_q) && !full)
      |-> f.we && f.wdata[`PXW_EOL_BIT] ##1 !hold_v_q)
      else $error("line end not flushed");
endmodule // pxw_link_rx

// ### design/pxw_packed_writer.sv
`timescale 1ns/10ps
`include "pxw_map.svh"
module pxw_packed_writer
(
   // Core clock and reset
   input wire logic clk,
   input wire logic srst,
   // Camera link
   input wire logic link_clk,
   input wire logic [`PXW_DATA_W-1:0] link_data,
   input wire logic link_fval,
   input wire logic link_lval,
   // Configuration
   input wire pxw_pkg::pxw_topo_t board_channel_layout,
   input wire pxw_pkg::pxw_tap_t tap_arrangement_setting,
   input wire pxw_pkg::pxw_geom_t tap_layout_setting,
   input wire pxw_pkg::pxw_fmt_t output_storage_format,
   input wire pxw_pkg::pxw_order_t line_order_scheme,
   input wire logic [7:0] line_order_block_count,
   input wire logic area_scan,
   input wire logic meta_enable,
   input wire logic [`PXW_DATA_W-1:0] meta_data,
   input wire logic [15:0] frame_lines,
   input wire logic [11:0] line_words,
   input wire logic [31:0] plane_stride,
   // Status
   output logic cfg_refused,
   output logic processing_bypass,
   output pxw_pkg::pxw_order_t line_order_effective,
   output logic [7:0] line_order_count,
   output logic fifo_overflow,
   // Buffer write stream
   output logic pix_valid,
   output logic pix_meta,
   output logic pix_first,
   output logic pix_last,
   output logic [31:0] pix_addr,
   output logic [`PXW_DATA_W-1:0] pix_data
);
   import pxw_pkg::*;

   pxw_fifo_if f ();
   logic run, link_ovf;
   logic [`PXW_PW-1:0] wg_s1_q, wg_s2_q;
   logic ovf_s1_q, ovf_s2_q;
   logic packed_on, topo_ok, geom_ok, fmt_ok, force_dual;
   logic eight_geom, two_geom;
   logic refused_q, refused_d, bypass_q, bypass_d;
   pxw_order_t order_q, order_d;
   logic [7:0] count_q, count_d;
   pxw_rd_state_t st_q, st_d;
   logic [`PXW_PW-1:0] rptr_q, rptr_d, rgray_q, rgray_d;
   logic [1:0] ml_q, ml_d, fields;
   logic [7:0] plane_q, plane_d, np;
   logic [15:0] row_q, row_d, nr, drow;
   logic [11:0] word_q, word_d, nw;
   logic empty, e_sof, e_sol, e_eol, emit;
   logic [31:0] pbase, addr;
   logic ov_q, ov_d, om_q, om_d, of_q, of_d, ol_q, ol_d;
   logic [31:0] oa_q, oa_d, last_pix_q;
   logic [`PXW_DATA_W-1:0] od_q, od_d;

   // ------
   // Link side and line FIFO
   // ------
   pxw_link_rx u_rx
   (
      .link_clk(link_clk),
      .link_data(link_data),
      .link_fval(link_fval),
      .link_lval(link_lval),
      .srst(srst),
      .run(run),
      .overflow(link_ovf),
      .f(f.wr)
   );

   pxw_line_fifo_mem u_mem
   (
      .wclk(link_clk),
      .w(f.mw),
      .rclk(clk),
      .r(f.mr)
   );

   always_ff @(posedge clk)
   begin
      wg_s1_q <= f.wgray;
      wg_s2_q <= wg_s1_q;
      ovf_s1_q <= link_ovf;
      ovf_s2_q <= ovf_s1_q;
   end

   // ------
   // Configuration check and line order
   // ------
   always_comb
   begin
      packed_on = tap_arrangement_setting != tap_other;
      topo_ok = board_channel_layout == single_channel_eighty_bit
         || board_channel_layout == single_channel_eighty_bit_alt;
      eight_geom = tap_layout_setting == single_row_eight_taps
         || tap_layout_setting == single_row_eight_taps_one_line;
      two_geom = tap_layout_setting == single_row_two_taps
         || tap_layout_setting == single_row_two_taps_one_line;
      unique case (tap_arrangement_setting)
         mono_eight_tap_tenbit_config:
         begin
            geom_ok = eight_geom;
            fmt_ok = output_storage_format == packed_mono_format;
         end
         rgb_eight_tap_three_cycle_config:
         begin
            geom_ok = eight_geom;
            fmt_ok = output_storage_format
               == packed_three_component_format;
         end
         rgbi_two_tap_config:
         begin
            geom_ok = two_geom;
            fmt_ok = output_storage_format
               == packed_four_component_format;
         end
         tap_other:
         begin
            geom_ok = 1'b1;
            fmt_ok = 1'b1;
         end
      endcase
      refused_d = packed_on && !(topo_ok && geom_ok && fmt_ok);
      bypass_d = packed_on;
      force_dual = area_scan
         && tap_layout_setting == two_region_converging_geometry;
      order_d = force_dual ? converging_two_region_order
         : line_order_scheme;
      unique case (order_d)
         progressive_order: count_d = `PXW_N_ONE;
         converging_two_region_order: count_d = `PXW_N_DUAL;
         n_line_plane_order: count_d = (line_order_block_count == 8'h00)
            ? `PXW_N_ONE : line_order_block_count;
         legacy_five_line_order: count_d = `PXW_N_LEGACY;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         refused_q <= 1'b0;
         bypass_q <= 1'b0;
         order_q <= progressive_order;
         count_q <= `PXW_N_ONE;
      end
      else
      begin
         refused_q <= refused_d;
         bypass_q <= bypass_d;
         order_q <= order_d;
         count_q <= count_d;
      end
   end

   assign run = bypass_q && !refused_q;

   // ------
   // FIFO read, reordering and metadata
   // ------
   assign e_sof = f.rdata[`PXW_SOF_BIT];
   assign e_sol = f.rdata[`PXW_SOL_BIT];
   assign e_eol = f.rdata[`PXW_EOL_BIT];
   assign empty = rgray_q == wg_s2_q;
   assign fields = area_scan ? `PXW_META_AREA : `PXW_META_LINE;

   always_comb
   begin
      np = plane_q;
      nr = row_q;
      nw = word_q + 12'h001;
      if (e_sof)
      begin
         np = '0;
         nr = '0;
         nw = '0;
      end
      else if (e_sol)
      begin
         // Each new line starts at word zero of its slot
         nw = '0;
         if (plane_q == count_q - 8'h01)
         begin
            np = '0;
            nr = row_q + 16'h0001;
         end
         else
         begin
            np = plane_q + 8'h01;
         end
      end
      // Odd lines of a converging pair fill from the bottom
      if (order_q == converging_two_region_order && np[0])
      begin
         drow = frame_lines - 16'h0001 - nr;
      end
      else
      begin
         drow = nr;
      end
      if (order_q == n_line_plane_order
         || order_q == legacy_five_line_order)
      begin
         pbase = {24'h000000, np} * plane_stride;
      end
      else
      begin
         pbase = '0;
      end
      addr = {16'h0000, drow} * {20'h00000, line_words} + pbase
         + {20'h00000, nw};
   end

   always_comb
   begin
      st_d = st_q;
      rptr_d = rptr_q;
      ml_d = ml_q;
      emit = 1'b0;
      f.re = 1'b0;
      ov_d = 1'b0;
      om_d = 1'b0;
      of_d = 1'b0;
      ol_d = 1'b0;
      oa_d = oa_q;
      od_d = od_q;
      plane_d = plane_q;
      row_d = row_q;
      word_d = word_q;
      unique case (st_q)
         rd_idle:
         begin
            if (!empty)
            begin
               f.re = 1'b1;
               rptr_d = rptr_q + 5'h01;
               st_d = rd_wait;
            end
         end
         rd_wait:
         begin
            if (e_sof && meta_enable)
            begin
               ml_d = fields;
               st_d = rd_meta;
            end
            else
            begin
               emit = 1'b1;
               st_d = rd_idle;
            end
         end
         rd_meta:
         begin
            ov_d = 1'b1;
            om_d = 1'b1;
            oa_d = {30'h00000000, fields - ml_q};
            od_d = meta_data;
            ml_d = ml_q - 2'h1;
            if (ml_q == 2'h1)
            begin
               st_d = rd_pix;
            end
         end
         rd_pix:
         begin
            emit = 1'b1;
            st_d = rd_idle;
         end
      endcase
      if (emit)
      begin
         ov_d = 1'b1;
         of_d = e_sof || e_sol;
         ol_d = e_eol;
         oa_d = addr;
         od_d = f.rdata[`PXW_DATA_W-1:0];
         plane_d = np;
         row_d = nr;
         word_d = nw;
      end
      rgray_d = rptr_d ^ (rptr_d >> 1);
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         st_q <= rd_idle;
         rptr_q <= '0;
         rgray_q <= '0;
         ml_q <= '0;
         plane_q <= '0;
         row_q <= '0;
         word_q <= '0;
         ov_q <= 1'b0;
         om_q <= 1'b0;
         of_q <= 1'b0;
         ol_q <= 1'b0;
         oa_q <= '0;
         od_q <= '0;
      end
      else
      begin
         st_q <= st_d;
         rptr_q <= rptr_d;
         rgray_q <= rgray_d;
         ml_q <= ml_d;
         plane_q <= plane_d;
         row_q <= row_d;
         word_q <= word_d;
         ov_q <= ov_d;
         om_q <= om_d;
         of_q <= of_d;
         ol_q <= ol_d;
         oa_q <= oa_d;
         od_q <= od_d;
      end
   end

   assign f.raddr = rptr_q[`PXW_AW-1:0];
   assign f.rgray = rgray_q;
   assign cfg_refused = refused_q;
   assign processing_bypass = bypass_q;
   assign line_order_effective = order_q;
   assign line_order_count = count_q;
   assign fifo_overflow = ovf_s2_q;
   assign pix_valid = ov_q;
   assign pix_meta = om_q;
   assign pix_first = of_q;
   assign pix_last = ol_q;
   assign pix_addr = oa_q;
   assign pix_data = od_q;

   // ------
   // Checks
   // ------
   always_ff @(posedge clk)
   begin
      if (ov_q && !om_q)
      begin
         last_pix_q <= oa_q;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   sequence s_meta_one;
      pix_valid && pix_meta ##1 pix_valid && !pix_meta;
   endsequence
   sequence s_meta_three;
      (pix_valid && pix_meta) [*3] ##1 pix_valid && !pix_meta;
   endsequence

   a_topo_refuse: assert property (
      packed_on && !topo_ok |=> cfg_refused && !run)
      else $error("bad layout not refused");
   a_eight_geom: assert property (
      (tap_arrangement_setting == mono_eight_tap_tenbit_config
      || tap_arrangement_setting == rgb_eight_tap_three_cycle_config)
      && !eight_geom |=> cfg_refused)
      else $error("eight-tap geometry not checked");
   a_two_geom: assert property (
      tap_arrangement_setting == rgbi_two_tap_config && !two_geom
      |=> cfg_refused)
      else $error("two-tap geometry not checked");
   a_fmt_match: assert property (
      packed_on && topo_ok && geom_ok && !fmt_ok |=> cfg_refused)
      else $error("format mismatch not refused");
   a_bypass_on: assert property (
      packed_on |=> processing_bypass)
      else $error("processing not bypassed");
   a_dual_forced: assert property (
      force_dual |=> line_order_effective == converging_two_region_order
      && line_order_count == `PXW_N_DUAL)
      else $error("dual-end not forced");
   a_prog_count: assert property (
      !force_dual && line_order_scheme == progressive_order
      |=> line_order_count == `PXW_N_ONE)
      else $error("progressive count wrong");
   a_meta_area: assert property (
      st_q == rd_wait && e_sof && meta_enable && area_scan
      |-> ##2 s_meta_one)
      else $error("area metadata not one field");
   a_meta_line: assert property (
      st_q == rd_wait && e_sof && meta_enable && !area_scan
      |-> ##2 s_meta_three)
      else $error("line metadata not three fields");
   a_addr_step: assert property (
      pix_valid && !pix_meta && !pix_first
      |-> pix_addr == last_pix_q + 32'h00000001)
      else $error("words out of order in line");
endmodule // pxw_packed_writer

// ### pkg/pxw_fifo_if.sv
`timescale 1ns/10ps
`include "pxw_map.svh"
interface pxw_fifo_if;
   logic we;
   logic [`PXW_AW-1:0] waddr;
   logic [`PXW_ENT_W-1:0] wdata;
   logic [`PXW_PW-1:0] wgray;
   logic re;
   logic [`PXW_AW-1:0] raddr;
   logic [`PXW_ENT_W-1:0] rdata;
   logic [`PXW_PW-1:0] rgray;
   modport wr (output we, waddr, wdata, wgray, input rgray);
   modport mw (input we, waddr, wdata);
   modport mr (input re, raddr, output rdata);
   modport rd (output re, raddr, rgray, input rdata, wgray);
endinterface

// ### pkg/pxw_map.svh
`ifndef PXW_MAP_SVH
`define PXW_MAP_SVH
// How it works
// - Mono: eight ten-bit pixels every link cycle
// - RGB: eight pixels over three link cycles
// - RGBI: two four-component pixels every link cycle
// - No widening to sixteen bits, no padding
// - Components packed least significant bit first
// - Camera component order kept in output
// - Storage format must match camera class
// - Ten-bit taps need eighty-bit single-channel layout
// - Eight-tap configs accept only eight-tap geometries
// - Two-tap RGBI accepts only two-tap geometries
// - Packed modes bypass all pixel processing
// - Metadata: one field area, three line-scan
// - Reordering done moving FIFO lines to buffer
// - Progressive: arrival order, count ignored
// - Dual-end: converging lines sorted, count two
// - Dual-end forced for converging area-scan
// - N-line: line k of block to plane k
// - Legacy five-line value still accepted

`define PXW_DATA_W 80
`define PXW_ENT_W 83
`define PXW_SOF_BIT 80
`define PXW_SOL_BIT 81
`define PXW_EOL_BIT 82
`define PXW_AW 4
`define PXW_PW 5
`define PXW_N_ONE 8'h01
`define PXW_N_DUAL 8'h02
`define PXW_N_LEGACY 8'h05
`define PXW_META_AREA 2'h1
`define PXW_META_LINE 2'h3
`endif

// ### pkg/pxw_pkg.sv
package pxw_pkg;
   typedef enum logic [1:0]
   {
      tap_other,
      mono_eight_tap_tenbit_config,
      rgb_eight_tap_three_cycle_config,
      rgbi_two_tap_config
   } pxw_tap_t;
   typedef enum logic [1:0]
   {
      fmt_other,
      packed_mono_format,
      packed_three_component_format,
      packed_four_component_format
   } pxw_fmt_t;
   typedef enum logic [1:0]
   {
      topo_other,
      single_channel_eighty_bit,
      single_channel_eighty_bit_alt
   } pxw_topo_t;
   typedef enum logic [2:0]
   {
      geom_other,
      single_row_eight_taps,
      single_row_eight_taps_one_line,
      single_row_two_taps,
      single_row_two_taps_one_line,
      two_region_converging_geometry
   } pxw_geom_t;
   typedef enum logic [1:0]
   {
      progressive_order,
      converging_two_region_order,
      n_line_plane_order,
      legacy_five_line_order
   } pxw_order_t;
   typedef enum {rd_idle, rd_wait, rd_meta, rd_pix} pxw_rd_state_t;
endpackage

// ### tb/pxw_camera_model.sv
`timescale 1ns/10ps
module pxw_camera_model
(
   // Link pins
   output logic link_clk,
   output logic [79:0] link_data,
   output logic link_fval,
   output logic link_lval
);
   logic on;
   // ------
   // Link clock, stands still low outside frames
   // ------
   initial
   begin
      link_clk = 1'b0;
      link_data = 80'h0;
      link_fval = 1'b0;
      link_lval = 1'b0;
      on = 1'b0;
      #7;
      forever
      begin
         #62.5;
         if (on || link_clk)
            link_clk = ~link_clk;
      end
   end
   // ------
   // Frames
   // ------
   function automatic logic [79:0] word_of(input int k);
      logic [79:0] w;
      for (int i = 0; i < 8; i++)
         w[10*i +: 10] = 10'((k * 8 + i) * 97 + 5);
      return w;
   endfunction
   task automatic send_frame(input int nl, input int nw, input int b);
      on = 1'b1;
      repeat (2) @(posedge link_clk);
      for (int l = 0; l < nl; l++)
      begin
         for (int w = 0; w < nw; w++)
         begin
            #1;
            link_fval = 1'b1;
            link_lval = 1'b1;
            link_data = word_of(b + l * nw + w);
            @(posedge link_clk);
         end
         // Released data shows the inverse of the last word
         #1;
         link_lval = 1'b0;
         link_data = ~link_data;
         repeat (2) @(posedge link_clk);
      end
      #1;
      link_fval = 1'b0;
      repeat (2) @(posedge link_clk);
      on = 1'b0;
   endtask
endmodule // pxw_camera_model

// ### tb/testbench.sv
`timescale 1ns/10ps
`include "pxw_map.svh"
module testbench;
   import pxw_pkg::*;
   // ------
   // Signals
   // ------
   logic clk, srst, link_clk, link_fval, link_lval, area, meta_en;
   logic [`PXW_DATA_W-1:0] link_data, pix_data;
   pxw_topo_t topo;
   pxw_tap_t tap;
   pxw_geom_t geom;
   pxw_fmt_t fmt;
   pxw_order_t ord, ord_eff;
   logic [7:0] bcnt, ord_cnt;
   logic [15:0] flines;
   logic [11:0] lwords;
   logic [31:0] stride, pix_addr;
   logic refused, bypass, ovf, pix_valid, pix_meta, pix_first, pix_last;
   logic [79:0] q_d[$];
   logic [31:0] q_a[$];
   logic [2:0] q_f[$];
   int n_mismatch = 0;
   int n_compared = 0;
   int cyc = 0;
   localparam logic [79:0] meta_word = 80'h5a5a_0123_4567_89ab_cdef;
   pxw_camera_model cam_u (.link_clk(link_clk), .link_data(link_data),
      .link_fval(link_fval), .link_lval(link_lval));
   pxw_packed_writer dut_u (.clk(clk), .srst(srst), .link_clk(link_clk),
      .link_data(link_data), .link_fval(link_fval), .link_lval(link_lval),
      .board_channel_layout(topo), .tap_arrangement_setting(tap),
      .tap_layout_setting(geom), .output_storage_format(fmt),
      .line_order_scheme(ord), .line_order_block_count(bcnt),
      .area_scan(area), .meta_enable(meta_en), .meta_data(meta_word),
      .frame_lines(flines), .line_words(lwords), .plane_stride(stride),
      .cfg_refused(refused), .processing_bypass(bypass),
      .line_order_effective(ord_eff), .line_order_count(ord_cnt),
      .fifo_overflow(ovf), .pix_valid(pix_valid), .pix_meta(pix_meta),
      .pix_first(pix_first), .pix_last(pix_last), .pix_addr(pix_addr),
      .pix_data(pix_data));
   // ------
   // Clock, collector, timeout
   // ------
   always #20 clk = ~clk;
   // Outputs launch on the rising edge, so they are taken on the falling one
   always @(negedge clk)
   begin
      if (!srst && pix_valid)
      begin
         q_d.push_back(pix_data);
         q_a.push_back(pix_addr);
         q_f.push_back({pix_meta, pix_first, pix_last});
      end
      cyc++;
      if (cyc == 20000)
      begin
         n_mismatch++;
         test_done();
      end
   end
   // ------
   // Shared tasks
   // ------
   task automatic check(input string what, input logic [79:0] seen,
      input logic [79:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic do_reset;
      @(negedge clk);
      srst = 1'b1;
      cam_u.on = 1'b1;
      repeat (14) @(negedge clk);
      srst = 1'b0;
      repeat (24) @(negedge clk);
      cam_u.on = 1'b0;
      q_d.delete();
      q_a.delete();
      q_f.delete();
   endtask
   task automatic wait_words(input int n);
      int k = 0;
      while (q_d.size() < n && k < 600)
      begin
         @(negedge clk);
         k++;
      end
      repeat (40) @(negedge clk);
   endtask
   task automatic test_done;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // ------
   // Scenarios
   // ------
   task automatic t_reset;
      @(negedge clk);
      srst = 1'b1;
      cam_u.on = 1'b1;
      repeat (14) @(negedge clk);
      check("reset valid", 80'(pix_valid), 80'h0);
      check("reset order", 80'(ord_eff), 80'(progressive_order));
      check("reset count", 80'(ord_cnt), 80'h1);
      $display("test reset done");
   endtask
   task automatic t_classes;
      pxw_tap_t t_l[3] = '{mono_eight_tap_tenbit_config,
         rgb_eight_tap_three_cycle_config, rgbi_two_tap_config};
      pxw_geom_t g_l[3] = '{single_row_eight_taps,
         single_row_eight_taps_one_line, single_row_two_taps_one_line};
      pxw_fmt_t f_l[3] = '{packed_mono_format,
         packed_three_component_format, packed_four_component_format};
      logic [79:0] w;
      for (int c = 0; c < 3; c++)
      begin
         tap = t_l[c];
         geom = g_l[c];
         fmt = f_l[c];
         topo = c[0] ? single_channel_eighty_bit_alt
                     : single_channel_eighty_bit;
         do_reset();
         check("bypass", 80'(bypass), 80'h1);
         check("refused", 80'(refused), 80'h0);
         cam_u.send_frame(1, 3, 10 * c);
         wait_words(3);
         check("count", 80'(q_d.size()), 80'h3);
         for (int i = 0; i < 3; i++)
         begin
            w = cam_u.word_of(10 * c + i);
            check("data", q_d[i], w);
            check("addr", 80'(q_a[i]), 80'(i));
            check("flags", 80'(q_f[i]), 80'({1'b0, i == 0, i == 2}));
            if (i == 0)
               check("byte1", 80'(q_d[0][15:8]),
                  80'({w[15:10], w[9:8]}));
         end
      end
      $display("test classes done");
   endtask
   task automatic t_refuse;
      pxw_topo_t o_l[4] = '{topo_other, single_channel_eighty_bit,
         single_channel_eighty_bit, single_channel_eighty_bit};
      pxw_tap_t t_l[4] = '{mono_eight_tap_tenbit_config,
         mono_eight_tap_tenbit_config, rgbi_two_tap_config,
         mono_eight_tap_tenbit_config};
      pxw_geom_t g_l[4] = '{single_row_eight_taps, single_row_two_taps,
         single_row_eight_taps, single_row_eight_taps};
      pxw_fmt_t f_l[4] = '{packed_mono_format, packed_mono_format,
         packed_four_component_format, packed_three_component_format};
      for (int c = 0; c < 4; c++)
      begin
         topo = o_l[c];
         tap = t_l[c];
         geom = g_l[c];
         fmt = f_l[c];
         do_reset();
         check("refused", 80'(refused), 80'h1);
         cam_u.send_frame(1, 2, 70);
         wait_words(1);
         check("no words", 80'(q_d.size()), 80'h0);
      end
      topo = single_channel_eighty_bit;
      tap = mono_eight_tap_tenbit_config;
      geom = single_row_eight_taps;
      fmt = packed_mono_format;
      $display("test refuse done");
   endtask
   task automatic t_order;
      pxw_order_t s_l[6] = '{progressive_order, converging_two_region_order,
         progressive_order, n_line_plane_order, n_line_plane_order,
         legacy_five_line_order};
      pxw_order_t e_l[6] = '{progressive_order, converging_two_region_order,
         converging_two_region_order, n_line_plane_order,
         n_line_plane_order, legacy_five_line_order};
      logic [7:0] n_l[6] = '{8'h07, 8'h07, 8'h07, 8'h03, 8'h00, 8'h09};
      logic [7:0] k_l[6] = '{8'h01, 8'h02, 8'h02, 8'h03, 8'h01, 8'h05};
      for (int c = 0; c < 6; c++)
      begin
         ord = s_l[c];
         bcnt = n_l[c];
         area = (c == 2);
         geom = (c == 2) ? two_region_converging_geometry
                         : single_row_eight_taps;
         do_reset();
         check("order", 80'(ord_eff), 80'(e_l[c]));
         check("order count", 80'(ord_cnt), 80'(k_l[c]));
      end
      area = 1'b0;
      geom = single_row_eight_taps;
      $display("test order done");
   endtask
   task automatic t_planes;
      logic [31:0] e_l[2][3] = '{'{0, 100, 1}, '{0, 3, 1}};
      int m;
      for (int c = 0; c < 2; c++)
      begin
         ord = c ? converging_two_region_order : n_line_plane_order;
         bcnt = 8'h02;
         meta_en = 1'b1;
         area = (c == 1);
         m = c ? 1 : 3;
         do_reset();
         cam_u.send_frame(3, 1, 50);
         wait_words(3 + m);
         check("count", 80'(q_d.size()), 80'(3 + m));
         for (int i = 0; i < m; i++)
         begin
            check("meta data", q_d[i], meta_word);
            check("meta field", 80'(q_a[i]), 80'(i));
            check("meta flag", 80'(q_f[i][2]), 80'h1);
         end
         for (int j = 0; j < 3; j++)
         begin
            check("plane data", q_d[m + j], cam_u.word_of(50 + j));
            check("plane addr", 80'(q_a[m + j]), 80'(e_l[c][j]));
            check("plane flags", 80'(q_f[m + j]), 80'h3);
         end
      end
      check("overflow", 80'(ovf), 80'h0);
      $display("test planes done");
   endtask
   // ------
   // Main sequence
   // ------
   initial
   begin
      clk = 1'b0;
      srst = 1'b1;
      topo = single_channel_eighty_bit;
      tap = mono_eight_tap_tenbit_config;
      geom = single_row_eight_taps;
      fmt = packed_mono_format;
      ord = progressive_order;
      bcnt = 8'h01;
      area = 1'b0;
      meta_en = 1'b0;
      flines = 16'h0004;
      lwords = 12'h003;
      stride = 32'h0000_0064;
      t_reset();
      t_classes();
      t_refuse();
      t_order();
      lwords = 12'h001;
      t_planes();
      test_done();
   end
endmodule // testbench
